// ==== core/itcw_pkg.sv ====
// Shared constants and carrier types for the interval timer wrapper
package itcw_pkg;

  // Byte addresses of the fixed board registers
  localparam logic [15:0] ITCW_ADDR_MASK = 16'h01E3;
  localparam logic [15:0] ITCW_ADDR_STAT = 16'h01E4;
  localparam logic [15:0] ITCW_ADDR_CTRL = 16'h01E5;
  localparam logic [15:0] ITCW_ADDR_BASE_HI = 16'h01E6;
  localparam logic [15:0] ITCW_ADDR_BASE_LO = 16'h01E7;

  // Reset values
  localparam logic [7:0] ITCW_CTRL_RST = 8'h00;
  localparam logic [7:0] ITCW_BASE_HI_RST = 8'h01;
  localparam logic [7:0] ITCW_BASE_LO_RST = 8'hDC;
  localparam logic [2:0] ITCW_MASK_RST = 3'h0;

  // Timer control field positions
  localparam int ITCW_CHAN2_GATE_BIT = 7;
  localparam int ITCW_CHAN1_GATE_BIT = 6;
  localparam int ITCW_CHAN0_GATE_BIT = 5;
  localparam int ITCW_CASCADE_BIT = 4;
  localparam int ITCW_CHAN1_CLK_BIT = 3;
  localparam int ITCW_CHAN0_CLK_BIT = 2;
  localparam logic [7:0] ITCW_CTRL_WMASK = 8'hFC;

  // Base low register: the two lowest bits take no part in decoding
  localparam int ITCW_BASE_LO_SKIP = 2;

  // Port offsets inside the four-byte timer window
  localparam logic [1:0] ITCW_PORT_CW = 2'h3;

  // Counter control word fields
  localparam int ITCW_CW_SC_LSB = 6;
  localparam int ITCW_CW_RW_LSB = 4;
  localparam int ITCW_CW_MODE_LSB = 1;
  localparam logic [1:0] ITCW_RW_LATCH = 2'h0;
  localparam logic [1:0] ITCW_RW_LSB = 2'h1;
  localparam logic [1:0] ITCW_RW_MSB = 2'h2;
  localparam logic [1:0] ITCW_RW_BOTH = 2'h3;

  // Internal timer clock: system clock divided by eight
  localparam int ITCW_TMR_DIV = 8;
  localparam logic [2:0] ITCW_DIV_LAST = 3'(ITCW_TMR_DIV - 1);

  typedef enum logic [1:0] {
    ITCW_M_TERM,
    ITCW_M_RATE,
    ITCW_M_SQUARE,
    ITCW_M_STROBE
  } itcw_mode_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } itcw_io_req_type;

  typedef struct packed {
    logic tick;
    logic gate;
    logic cw_wr;
    logic data_wr;
    logic data_rd;
    logic [7:0] wdata;
  } itcw_chan_in_type;

endpackage : itcw_pkg

// ==== core/itcw_counter.sv ====
// One 16-bit binary counter channel with control word and byte ports
`timescale 1ns/1ps
module itcw_counter
  import itcw_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire itcw_chan_in_type i_chan,
  output logic [7:0] o_rdata,
  output logic o_out
);

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] reload;
    logic [15:0] latch;
    logic latched;
    itcw_mode_type mode;
    logic [1:0] rw;
    logic bcd;
    logic wr_msb;
    logic rd_msb;
    logic load_pend;
    logic armed;
    logic out;
  } itcw_cnt_state_type;

  itcw_cnt_state_type s;
  itcw_cnt_state_type next_s;
  logic [15:0] rd_src;

  function automatic itcw_mode_type itcw_map_mode(input logic [2:0] m);
    if (m[1:0] == 2'h2) begin
      return ITCW_M_RATE;
    end else if (m[1:0] == 2'h3) begin
      return ITCW_M_SQUARE;
    end else if (m[2]) begin
      return ITCW_M_STROBE;
    end
    return ITCW_M_TERM;
  endfunction : itcw_map_mode

  assign rd_src = s.latched ? s.latch : s.count;
  assign o_rdata = (s.rw == ITCW_RW_MSB || (s.rw == ITCW_RW_BOTH && s.rd_msb))
                   ? rd_src[15:8] : rd_src[7:0];
  assign o_out = s.out;

  always_comb begin
    next_s = s;
    if (i_chan.cw_wr) begin
      if (i_chan.wdata[ITCW_CW_RW_LSB +: 2] == ITCW_RW_LATCH) begin
        if (!s.latched) begin
          next_s.latch = s.count;
          next_s.latched = 1'b1;
        end
      end else begin
        next_s.rw = i_chan.wdata[ITCW_CW_RW_LSB +: 2];
        next_s.mode = itcw_map_mode(i_chan.wdata[ITCW_CW_MODE_LSB +: 3]);
        // Stored but never read back or used; counting stays binary
        next_s.bcd = i_chan.wdata[0];
        next_s.wr_msb = 1'b0;
        next_s.rd_msb = 1'b0;
        next_s.armed = 1'b0;
        next_s.load_pend = 1'b0;
        next_s.out = (next_s.mode != ITCW_M_TERM);
      end
    end
    if (i_chan.data_wr) begin
      case (s.rw)
        ITCW_RW_LSB: begin
          next_s.reload = {8'h00, i_chan.wdata};
          next_s.load_pend = 1'b1;
        end
        ITCW_RW_MSB: begin
          next_s.reload = {i_chan.wdata, 8'h00};
          next_s.load_pend = 1'b1;
        end
        ITCW_RW_BOTH: begin
          if (!s.wr_msb) begin
            next_s.reload[7:0] = i_chan.wdata;
            next_s.wr_msb = 1'b1;
            // Terminal mode halts while only half a count is written
            if (s.mode == ITCW_M_TERM) begin
              next_s.armed = 1'b0;
            end
          end else begin
            next_s.reload[15:8] = i_chan.wdata;
            next_s.wr_msb = 1'b0;
            next_s.load_pend = 1'b1;
          end
        end
        default: begin
        end
      endcase
      if (s.mode == ITCW_M_TERM) begin
        next_s.out = 1'b0;
      end
    end
    if (i_chan.data_rd) begin
      if (s.rw == ITCW_RW_BOTH) begin
        next_s.rd_msb = !s.rd_msb;
        if (s.rd_msb) begin
          next_s.latched = 1'b0;
        end
      end else begin
        next_s.latched = 1'b0;
      end
    end
    if (!i_chan.gate && (s.mode == ITCW_M_RATE || s.mode == ITCW_M_SQUARE)) begin
      next_s.out = 1'b1;
    end
    if (i_chan.tick && !i_chan.cw_wr && !i_chan.data_wr) begin
      if (s.load_pend) begin
        next_s.count = s.reload;
        next_s.load_pend = 1'b0;
        next_s.armed = 1'b1;
      end else if (s.armed && i_chan.gate) begin
        // Binary count only
        case (s.mode)
          ITCW_M_TERM: begin
            next_s.count = s.count - 16'h0001;
            if (s.count == 16'h0001) begin
              next_s.out = 1'b1;
            end
          end
          ITCW_M_STROBE: begin
            next_s.count = s.count - 16'h0001;
            next_s.out = (s.count != 16'h0001);
          end
          ITCW_M_RATE: begin
            if (s.count == 16'h0001) begin
              next_s.count = s.reload;
              next_s.out = 1'b1;
            end else begin
              next_s.count = s.count - 16'h0001;
              next_s.out = (s.count != 16'h0002);
            end
          end
          ITCW_M_SQUARE: begin
            if (s.count == 16'h0001 || s.count == 16'h0002) begin
              next_s.count = s.reload;
              next_s.out = !s.out;
            end else begin
              next_s.count = s.count - 16'h0002;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule : itcw_counter

// ==== core/itcw_top.sv ====
// Interval timer wrapper: control, base decode, clocking, status flags
//
// Function
// - Each channel gate follows its control bit D7, D6, D5; 1 high, 0 low.
// - Cascade bit 0 chains channels 1 and 2; bit 1 keeps channel 2 alone.
// - Channel 1 clock is internal when D3 is 0, external input b when 1.
// - Channel 0 clock is internal when D2 is 0, external input a when 1.
// - Three independent 16-bit binary counters; the BCD bit is kept, unused.
// - In cascade, channel 1 is the low half, channel 2 the high half.
// - In cascade, channel 1 output clocks channel 2.
// - Internal timer clock is the bus clock divided by eight.
// - External input a only feeds channel 0, input b only channel 1.
// - Channel 2 runs on the internal clock except in cascade mode.
// - A rising channel output sets its sticky status bit.
// - Timers occupy four byte addresses at a four-byte aligned base.
// - Base high byte is read/write and resets to 01h.
// - Base low byte is read/write and resets to DCh, base 1DCh.
// - The two lowest base bits are ignored when decoding.
// - Writing one clears a status bit; status reads regardless of mask.
// - Mask bit 1 lets its status bit drive the interrupt output.
`timescale 1ns/1ps
module itcw_top
  import itcw_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_sys_rst,
  input wire itcw_io_req_type i_io,
  input wire logic i_ext_clock_in_a,
  input wire logic i_ext_clock_in_b,
  output logic o_io_hit,
  output logic [7:0] o_io_rdata,
  output logic [2:0] o_chan_gate,
  output logic [2:0] o_chan_out,
  output logic o_irq
);

  typedef struct packed {
    logic [7:0] timer_control;
    logic [7:0] timer_base_high;
    logic [7:0] timer_base_low;
    logic [2:0] irq_enable;
    logic [2:0] irq_flag;
    logic [2:0] div_cnt;
    logic [1:0] ext_s1;
    logic [1:0] ext_s2;
    logic [1:0] ext_s3;
    logic [2:0] out_prev;
    logic [7:0] rdata;
  } itcw_top_state_type;

  itcw_top_state_type s;
  itcw_top_state_type next_s;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  logic reg_hit;
  logic tmr_hit;
  logic [15:2] base_word;
  logic div_tick;
  logic [1:0] ext_edge;
  logic [2:0] chan_tick;
  logic [2:0] out_rise;
  logic cascade;
  logic [7:0] chan_rdata [3];
  itcw_chan_in_type chan_in [3];

  function automatic logic itcw_is_reg(input logic [15:0] a);
    return a == ITCW_ADDR_MASK || a == ITCW_ADDR_STAT ||
           a == ITCW_ADDR_CTRL || a == ITCW_ADDR_BASE_HI ||
           a == ITCW_ADDR_BASE_LO;
  endfunction : itcw_is_reg

  function automatic logic itcw_reg_wr(input itcw_io_req_type r,
                                       input logic [15:0] a);
    return r.wr && r.addr == a;
  endfunction : itcw_reg_wr

  // Base bits 1:0 are left out of the compare
  assign base_word = {s.timer_base_high,
                      s.timer_base_low[7:ITCW_BASE_LO_SKIP]};
  assign reg_hit = itcw_is_reg(i_io.addr);
  // Fixed registers win if software moves the window over them
  assign tmr_hit = !reg_hit && i_io.addr[15:2] == base_word;
  assign o_io_hit = reg_hit || tmr_hit;
  assign o_io_rdata = s.rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Timer clocking

  assign div_tick = s.div_cnt == ITCW_DIV_LAST;
  // Only the second and third stages are looked at
  assign ext_edge = s.ext_s2 & ~s.ext_s3;
  assign cascade = !s.timer_control[ITCW_CASCADE_BIT];
  assign out_rise = o_chan_out & ~s.out_prev;

  always_comb begin
    // External input a serves channel 0 alone, b channel 1
    chan_tick[0] = s.timer_control[ITCW_CHAN0_CLK_BIT] ? ext_edge[0]
                                                       : div_tick;
    chan_tick[1] = s.timer_control[ITCW_CHAN1_CLK_BIT] ? ext_edge[1]
                                                       : div_tick;
    // Channel 2 counts channel 1 wraps as the high half
    chan_tick[2] = cascade ? out_rise[1] : div_tick;
  end

  assign o_chan_gate = {s.timer_control[ITCW_CHAN2_GATE_BIT],
                        s.timer_control[ITCW_CHAN1_GATE_BIT],
                        s.timer_control[ITCW_CHAN0_GATE_BIT]};

  ////////////////////////////////////////////////////////////////////////////
  // Counter channels

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_chan
      always_comb begin
        chan_in[gi].tick = chan_tick[gi];
        chan_in[gi].gate = o_chan_gate[gi];
        chan_in[gi].cw_wr = tmr_hit && i_io.wr &&
                            i_io.addr[1:0] == ITCW_PORT_CW &&
                            i_io.wdata[ITCW_CW_SC_LSB +: 2] == 2'(gi);
        chan_in[gi].data_wr = tmr_hit && i_io.wr &&
                              i_io.addr[1:0] == 2'(gi);
        chan_in[gi].data_rd = tmr_hit && i_io.rd &&
                              i_io.addr[1:0] == 2'(gi);
        chan_in[gi].wdata = i_io.wdata;
      end
      itcw_counter u_cnt (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_chan(chan_in[gi]),
        .o_rdata(chan_rdata[gi]),
        .o_out(o_chan_out[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Registers and flags

  assign o_irq = |(s.irq_flag & s.irq_enable);

  always_comb begin
    next_s = s;
    next_s.div_cnt = div_tick ? 3'h0 : s.div_cnt + 3'h1;
    next_s.ext_s1 = {i_ext_clock_in_b, i_ext_clock_in_a};
    next_s.ext_s2 = s.ext_s1;
    next_s.ext_s3 = s.ext_s2;
    next_s.out_prev = o_chan_out;
    if (itcw_reg_wr(i_io, ITCW_ADDR_CTRL)) begin
      // Reserved low bits are dropped
      next_s.timer_control = i_io.wdata & ITCW_CTRL_WMASK;
    end
    if (itcw_reg_wr(i_io, ITCW_ADDR_BASE_HI)) begin
      next_s.timer_base_high = i_io.wdata;
    end
    if (itcw_reg_wr(i_io, ITCW_ADDR_BASE_LO)) begin
      next_s.timer_base_low = i_io.wdata;
    end
    if (itcw_reg_wr(i_io, ITCW_ADDR_MASK)) begin
      next_s.irq_enable = i_io.wdata[2:0];
    end
    // A new rising edge beats a clear in the same cycle
    next_s.irq_flag = s.irq_flag & ~(itcw_reg_wr(i_io, ITCW_ADDR_STAT)
                                     ? i_io.wdata[2:0] : 3'h0);
    next_s.irq_flag = next_s.irq_flag | out_rise;
    if (i_io.rd) begin
      case (i_io.addr)
        ITCW_ADDR_MASK: next_s.rdata = {5'h00, s.irq_enable};
        ITCW_ADDR_STAT: next_s.rdata = {5'h00, s.irq_flag};
        ITCW_ADDR_CTRL: next_s.rdata = s.timer_control;
        ITCW_ADDR_BASE_HI: next_s.rdata = s.timer_base_high;
        ITCW_ADDR_BASE_LO: next_s.rdata = s.timer_base_low;
        default: begin
          if (tmr_hit && i_io.addr[1:0] != ITCW_PORT_CW) begin
            next_s.rdata = chan_rdata[i_io.addr[1:0]];
          end else begin
            next_s.rdata = 8'h00;
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s <= '0;
      s.timer_control <= ITCW_CTRL_RST;
      s.timer_base_high <= ITCW_BASE_HI_RST;
      s.timer_base_low <= ITCW_BASE_LO_RST;
      s.irq_enable <= ITCW_MASK_RST;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  property p_gate;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_io.wr && i_io.addr == ITCW_ADDR_CTRL)
      |=> o_chan_gate == $past(i_io.wdata[7:5]);
  endproperty
  a_gate: assert property (p_gate)
    else $error("gate levels do not follow control write");

  property p_div;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    div_tick |=> !div_tick [*7] ##1 div_tick;
  endproperty
  a_div: assert property (p_div)
    else $error("internal timer tick not one in eight");

  property p_ch0_src;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    s.timer_control[ITCW_CHAN0_CLK_BIT] |-> chan_tick[0] == ext_edge[0];
  endproperty
  a_ch0_src: assert property (p_ch0_src)
    else $error("channel 0 not on external input a");

  property p_ch1_src;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    !s.timer_control[ITCW_CHAN1_CLK_BIT] |-> chan_tick[1] == div_tick;
  endproperty
  a_ch1_src: assert property (p_ch1_src)
    else $error("channel 1 not on internal clock");

  property p_ch2_src;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    s.timer_control[ITCW_CASCADE_BIT] |-> chan_tick[2] == div_tick;
  endproperty
  a_ch2_src: assert property (p_ch2_src)
    else $error("channel 2 not on internal clock");

  property p_cascade;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (!s.timer_control[ITCW_CASCADE_BIT] && $rose(o_chan_out[1]))
      |-> chan_tick[2];
  endproperty
  a_cascade: assert property (p_cascade)
    else $error("channel 1 output did not clock channel 2");

  property p_sync;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (!i_ext_clock_in_a ##1 i_ext_clock_in_a) |-> ##2 ext_edge[0];
  endproperty
  a_sync: assert property (p_sync)
    else $error("external input a edge not seen two cycles later");

  // A clear written just after the rise may legally drop the bit again
  property p_flag;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    out_rise[0] |=> s.irq_flag[0] ##1
      (s.irq_flag[0] ||
       $past(i_io.wr && i_io.addr == ITCW_ADDR_STAT && i_io.wdata[0]));
  endproperty
  a_flag: assert property (p_flag)
    else $error("rising output did not set its status bit");

  property p_clear;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (i_io.wr && i_io.addr == ITCW_ADDR_STAT && i_io.wdata[1] && !out_rise[1])
      |=> !s.irq_flag[1];
  endproperty
  a_clear: assert property (p_clear)
    else $error("write of one did not clear status");

  property p_irq;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (out_rise[2] && s.irq_enable[2] &&
     !(i_io.wr && i_io.addr == ITCW_ADDR_MASK)) |=> o_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled status did not raise interrupt");

  property p_decode;
    @(posedge i_sys_clk) disable iff (i_sys_rst)
    (!reg_hit && i_io.addr[15:8] == s.timer_base_high &&
     i_io.addr[7:2] == s.timer_base_low[7:2]) |-> o_io_hit;
  endproperty
  a_decode: assert property (p_decode)
    else $error("timer window address not claimed");

endmodule : itcw_top

// ==== testbench/itcw_host_model.sv ====
// Host processor model issuing byte-wide I/O cycles to the timer wrapper
`timescale 1ns/1ps
module itcw_host_model
  import itcw_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic [7:0] i_io_rdata,
  output itcw_io_req_type o_io
);

  initial o_io = '{addr: 16'h0000, wdata: 8'h00, wr: 1'b0, rd: 1'b0};

  ////////////////////////////////////////////////////////////////////////
  // Released lines flip so a stale address or byte never looks valid
  task automatic put(input logic [15:0] a, input logic [7:0] d,
                     input logic w);
    @(posedge i_sys_clk);
    o_io <= '{addr: a, wdata: d, wr: w, rd: ~w};
    @(posedge i_sys_clk);
    o_io <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : put

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == ITCW_ADDR_CTRL) v[1:0] = 2'b00;
    if (a == ITCW_ADDR_BASE_LO) v[1:0] = 2'b00;
    put(a, v, 1'b1);
  endtask : wr

  // Unmasked write, used only where a bad low base field is wanted
  task automatic wr_raw(input logic [15:0] a, input logic [7:0] d);
    put(a, d, 1'b1);
  endtask : wr_raw

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    put(a, 8'h00, 1'b0);
    #1;
    d = i_io_rdata;
  endtask : rd

  // Address only, no strobe, so the decoder can be probed
  task automatic aim(input logic [15:0] a);
    @(posedge i_sys_clk);
    o_io <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
  endtask : aim

endmodule : itcw_host_model

// ==== testbench/interval_timer_control_wrapper_tb_top.sv ====
// Self-checking testbench for the interval timer wrapper
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    checks_done++; \
    if ((g) !== (e)) begin \
      errors++; \
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
    end \
  end
module interval_timer_control_wrapper_tb_top
  import itcw_pkg::*;
;
  logic i_sys_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic ext_a = 1'b0;
  logic ext_b = 1'b0;
  logic run_a = 1'b0;
  logic run_b = 1'b0;
  logic [1:0] ext_div = 2'h0;
  itcw_io_req_type io_bus;
  logic o_io_hit;
  logic [7:0] o_io_rdata;
  logic [2:0] o_chan_gate;
  logic [2:0] o_chan_out;
  logic o_irq;
  int errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int p;

  always #12.5 i_sys_clk = ~i_sys_clk;

  itcw_host_model host (.i_sys_clk(i_sys_clk), .i_io_rdata(o_io_rdata),
    .o_io(io_bus));

  itcw_top uut (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
    .i_io(io_bus), .i_ext_clock_in_a(ext_a), .i_ext_clock_in_b(ext_b),
    .o_io_hit(o_io_hit), .o_io_rdata(o_io_rdata),
    .o_chan_gate(o_chan_gate), .o_chan_out(o_chan_out), .o_irq(o_irq));

  // External pins toggle every 3 clocks, a 6-clock period when running
  always @(posedge i_sys_clk) begin
    ext_div <= (ext_div == 2'h2) ? 2'h0 : ext_div + 2'h1;
    if (ext_div == 2'h2) begin
      if (run_a) ext_a <= ~ext_a;
      if (run_b) ext_b <= ~ext_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  always @(posedge i_sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end

  task automatic rd_chk(input string nm, input logic [15:0] a,
                        input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    `CHK(nm, e, d)
  endtask : rd_chk

  task automatic hit_chk(input logic [15:0] a, input logic e);
    host.aim(a);
    #1;
    `CHK("io_hit", e, o_io_hit)
  endtask : hit_chk

  // Control word at base+3, then low and high count bytes
  task automatic prog(input logic [1:0] ch, input logic [2:0] md,
                      input logic [15:0] cnt);
    host.wr(16'h01DF, {ch, 2'b11, md, 1'b0});
    host.wr(16'h01DC + 16'(ch), cnt[7:0]);
    host.wr(16'h01DC + 16'(ch), cnt[15:8]);
  endtask : prog

  // Clocks between the second and third rising edge; -1 if none in lim
  task automatic period(input int idx, input int lim, output int pr);
    int n;
    int r;
    int t0;
    logic prv;
    n = 0;
    r = 0;
    t0 = 0;
    pr = -1;
    prv = o_chan_out[idx];
    while (n < lim && pr < 0) begin
      @(posedge i_sys_clk);
      n++;
      if (o_chan_out[idx] === 1'b1 && prv === 1'b0) begin
        r++;
        if (r == 2) t0 = n;
        if (r == 3) pr = n - t0;
      end
      prv = o_chan_out[idx];
    end
  endtask : period

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd_chk("ctrl", ITCW_ADDR_CTRL, 8'h00);
    rd_chk("base_hi", ITCW_ADDR_BASE_HI, 8'h01);
    rd_chk("base_lo", ITCW_ADDR_BASE_LO, 8'hDC);
    rd_chk("unmapped", 16'h01E8, 8'h00);
    `CHK("gates", 3'b000, o_chan_gate)
    hit_chk(16'h01DB, 1'b0);
    hit_chk(16'h01DC, 1'b1);
    hit_chk(16'h01DF, 1'b1);
    hit_chk(16'h01E0, 1'b0);
  endtask : t_reset

  task automatic t_ctrl();
    logic [7:0] v[4] = '{8'hA0, 8'h40, 8'h80, 8'h20};
    for (int i = 0; i < 4; i++) begin
      host.wr(ITCW_ADDR_CTRL, v[i]);
      #1;
      `CHK("gates", v[i][7:5], o_chan_gate)
      rd_chk("ctrl", ITCW_ADDR_CTRL, v[i]);
    end
  endtask : t_ctrl

  task automatic t_base();
    host.wr_raw(ITCW_ADDR_BASE_HI, 8'h03);
    host.wr_raw(ITCW_ADDR_BASE_LO, 8'h43);
    hit_chk(16'h01DC, 1'b0);
    hit_chk(16'h0340, 1'b1);
    hit_chk(16'h0343, 1'b1);
    hit_chk(16'h0344, 1'b0);
    hit_chk(16'h033F, 1'b0);
    rd_chk("base_lo", ITCW_ADDR_BASE_LO, 8'h43);
    host.wr(ITCW_ADDR_BASE_HI, 8'h01);
    host.wr(ITCW_ADDR_BASE_LO, 8'hDC);
    hit_chk(16'h01DD, 1'b1);
  endtask : t_base

  task automatic t_status();
    host.wr(ITCW_ADDR_CTRL, 8'h20);
    prog(2'd0, 3'd2, 16'h0003);
    period(0, 300, p);
    `CHK("ch0_period", 24, p)
    rd_chk("status", ITCW_ADDR_STAT, 8'h01);
    `CHK("irq_masked", 1'b0, o_irq)
    host.wr(ITCW_ADDR_MASK, 8'h01);
    repeat (2) @(posedge i_sys_clk);
    #1;
    `CHK("irq_enabled", 1'b1, o_irq)
    // Gate low parks the output so no new edge races the clear
    host.wr(ITCW_ADDR_CTRL, 8'h00);
    repeat (40) @(posedge i_sys_clk);
    rd_chk("status_held", ITCW_ADDR_STAT, 8'h01);
    host.wr(ITCW_ADDR_STAT, 8'h01);
    rd_chk("status_clr", ITCW_ADDR_STAT, 8'h00);
    `CHK("irq_clr", 1'b0, o_irq)
    host.wr(ITCW_ADDR_MASK, 8'h00);
    // Gate low freezes the loaded count so the latched bytes are known
    prog(2'd0, 3'd2, 16'h1234);
    repeat (10) @(posedge i_sys_clk);
    host.wr(16'h01DF, 8'h00);
    rd_chk("cnt_lsb", 16'h01DC, 8'h34);
    rd_chk("cnt_msb", 16'h01DC, 8'h12);
  endtask : t_status

  task automatic t_ext();
    host.wr(ITCW_ADDR_CTRL, 8'h24);
    prog(2'd0, 3'd2, 16'h0002);
    run_b <= 1'b1;
    period(0, 150, p);
    `CHK("ch0_still", -1, p)
    run_a <= 1'b1;
    period(0, 300, p);
    `CHK("ch0_ext", 12, p)
    host.wr(ITCW_ADDR_CTRL, 8'h58);
    prog(2'd1, 3'd2, 16'h0002);
    run_a <= 1'b0;
    period(1, 300, p);
    `CHK("ch1_ext", 12, p)
    run_b <= 1'b0;
    run_a <= 1'b1;
    period(1, 150, p);
    `CHK("ch1_still", -1, p)
    run_a <= 1'b0;
  endtask : t_ext

  // Short channel 1 count keeps the run brief; the full range is optional
  task automatic t_cascade();
    host.wr(ITCW_ADDR_CTRL, 8'hC0);
    prog(2'd1, 3'd2, 16'h0002);
    prog(2'd2, 3'd2, 16'h0003);
    period(1, 300, p);
    `CHK("ch1_int", 16, p)
    period(2, 600, p);
    `CHK("ch2_casc", 48, p)
    rd_chk("status_all", ITCW_ADDR_STAT, 8'h07);
    host.wr(ITCW_ADDR_MASK, 8'h04);
    host.wr(ITCW_ADDR_CTRL, 8'hD0);
    period(2, 300, p);
    `CHK("ch2_alone", 24, p)
    #1;
    `CHK("irq_ch2", 1'b1, o_irq)
    // Count of 16 must stay binary with the BCD bit set
    host.wr(16'h01DF, 8'hB5);
    host.wr(16'h01DE, 8'h10);
    host.wr(16'h01DE, 8'h00);
    period(2, 600, p);
    `CHK("ch2_binary", 128, p)
  endtask : t_cascade

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge i_sys_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_ctrl();
    t_base();
    t_status();
    t_ext();
    t_cascade();
    close_out();
  end

endmodule : interval_timer_control_wrapper_tb_top
